// [src/uart_cfg_pkg.sv]
// Purpose: constants shared by the uart channel configuration block
// Assumes: 16-bit registers reached by vendor register requests
// Notes:   offsets are request addresses
package uart_cfg_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   // register offsets
   localparam logic [15:0] ADDR_DIR_ENABLE = 16'h0040;
   localparam logic [15:0] ADDR_CHAR_FMT   = 16'h0045;
   localparam logic [15:0] ADDR_HANDSHAKE  = 16'h0046;
   localparam logic [15:0] ADDR_RESUME     = 16'h0047;
   localparam logic [15:0] ADDR_PAUSE      = 16'h0048;
   localparam logic [15:0] ADDR_LINE_ERR   = 16'h0049;
   localparam logic [15:0] ADDR_BREAK      = 16'h004A;
   localparam logic [15:0] ADDR_TURNAROUND = 16'h004B;
   localparam logic [15:0] ADDR_PIN_FUNC   = 16'h004C;
   localparam logic [15:0] ADDR_PIN_DIR    = 16'h004D;
   localparam logic [15:0] ADDR_DRIVE_HIGH = 16'h004E;
   localparam logic [15:0] ADDR_DRIVE_LOW  = 16'h004F;
   localparam logic [15:0] ADDR_PIN_LEVEL  = 16'h0050;
   // field positions
   localparam int ENA_RX_BIT   = 1;
   localparam int ENA_TX_BIT   = 0;
   localparam int FMT_STOP_BIT = 7;
   localparam int HALF_BIT     = 3;
   localparam int POL_BIT      = 3;
   localparam int ERR_LIVE_BIT = 7;
   localparam int ERR_LSB      = 3;
   localparam int PIN_REQ      = 5;
   localparam int PIN_CTS      = 4;
   localparam int PIN_DTR      = 3;
   localparam int PIN_DSR      = 2;
   // reset values and the endless break count
   localparam logic [7:0]  FMT_RESET    = 8'h08;
   localparam logic [7:0]  RESUME_RESET = 8'h11;
   localparam logic [7:0]  PAUSE_RESET  = 8'h13;
   localparam logic [15:0] BREAK_FOREVER = 16'hFFFF;
   // pin function codes
   localparam logic [2:0] PF_GPIO   = 3'h0;
   localparam logic [2:0] PF_RTS    = 3'h1;
   localparam logic [2:0] PF_DTR    = 3'h2;
   localparam logic [2:0] PF_DE_TX  = 3'h3;
   localparam logic [2:0] PF_DE_ADR = 3'h4;
   // break tick timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int BREAK_TICK_NS = 1000000;
   localparam int BREAK_TICK_CYCLES = BREAK_TICK_NS / CLK_PERIOD_NS;
   localparam int MS_CNT_W = 18;
endpackage : uart_cfg_pkg

// [src/word_stream_if.sv]
// Purpose: valid/ready word carrier between the block's modules
// Assumes: one clock domain
// Notes:   producer drives valid and data, consumer drives ready
`timescale 1ns/1ps
interface word_stream_if;
   logic        valid;
   logic        ready;
   logic [15:0] data;
   modport producer (output valid, output data, input ready);
   modport consumer (input valid, input data, output ready);
endinterface : word_stream_if

// [src/two_entry_buffer.sv]
// Purpose: two-entry buffer for register answers
// Assumes: single clock, asynchronous active-low reset
// Notes:   fill ready drops only when both entries hold
`timescale 1ns/1ps
module two_entry_buffer (
   // clock and reset
   input wire logic        clk_sys_i,
   input wire logic        rst_b_i,
   // streams
   word_stream_if.consumer fill_if,
   word_stream_if.producer drain_if
);
   typedef struct packed {
      logic [1:0][15:0] mem;
      logic             wr_ptr;
      logic             rd_ptr;
      logic [1:0]       count;
   } buf_state_t;

   buf_state_t buf_ff;
   buf_state_t nxt_buf;
   logic       push;
   logic       pop;

   // full and empty from the occupancy count
   assign fill_if.ready  = (buf_ff.count != 2'h2);
   assign drain_if.valid = (buf_ff.count != 2'h0);
   assign drain_if.data  = buf_ff.mem[buf_ff.rd_ptr];
   assign push = fill_if.valid && fill_if.ready;
   assign pop  = drain_if.valid && drain_if.ready;

   // pointer and count update
   always_comb begin
      nxt_buf = buf_ff;
      if (push) begin
         nxt_buf.mem[buf_ff.wr_ptr] = fill_if.data;
         nxt_buf.wr_ptr = ~buf_ff.wr_ptr;
      end
      if (pop) begin
         nxt_buf.rd_ptr = ~buf_ff.rd_ptr;
      end
      if (push && !pop) begin
         nxt_buf.count = buf_ff.count + 2'h1;
      end else if (pop && !push) begin
         nxt_buf.count = buf_ff.count - 2'h1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         buf_ff <= '0;
      end else begin
         buf_ff <= nxt_buf;
      end
   end
endmodule : two_entry_buffer

// [src/uart_config_break_gpio_regs.sv]
// Purpose: configuration, error, break, driver-enable and pin logic of a uart
// Assumes: uart core signals share clk_sys_i; pins are asynchronous
// Notes:   every accepted request yields one answer word through a buffer
`timescale 1ns/1ps
// Functional notes
// R01: enable bit 1 gates receiver, bit 0 transmitter; both off after reset.
// R02: format bit 7 selects one or two stop bits.
// R03: format bits 6:4 select none, odd, even, mark or space parity.
// R04: format bits 3:0 select 7, 8 or 9 data bits; resets to 8.
// R05: half-duplex bit blocks reception while the transmitter sends.
// R06: flow mode bits 2:0 select none, hardware, software, address match modes.
// R07: resume and pause characters reset to 0x11 and 0x13.
// R08: overrun, parity, framing, break flags latch until status is read.
// R09: status bit 7 shows live break on the receive line.
// R10: nonzero break count forces break, decremented per millisecond until zero.
// R11: all-ones count holds break forever; zero stops it.
// R12: driver enable holds turnaround bit times after sending.
// R13: pin function bit 3 sets the driver-enable polarity.
// R14: function codes 0, 1, 2 give general pins, request/clear, ready pins.
// R15: codes 3 and 4 give driver enable on send or address match.
// R16: direction bits make pins outputs when set; inputs after reset.
// R17: drive-high ones raise output pins.
// R18: drive-low ones lower output pins.
// R19: pin level register returns all six pin levels.
// R20: software manages pull-ups when it changes pin direction.
// R21: host writes zero to reserved bits.
// R22: line-coding requests also update the format; one that arrives with an accepted register write in the same cycle is dropped.
// R23: registers are reached only by vendor requests.
// R24: registers are 16 bits; unstated defaults are zero.
// R25: millisecond and bit-time ticks pace break and turnaround.
// R26: status read clears flags without losing new events.
module uart_config_break_gpio_regs #(
   parameter int MS_CYCLES = uart_cfg_pkg::BREAK_TICK_CYCLES
) (
   // clock and reset
   input  wire logic                            clk_sys_i,
   input  wire logic                            rst_b_i,
   // vendor register requests
   input  wire logic                            req_valid_i,
   output logic                                 req_ready_o,
   input  wire logic                            req_write_i,
   input  wire logic [uart_cfg_pkg::ADDR_W-1:0] req_addr_i,
   input  wire logic [uart_cfg_pkg::DATA_W-1:0] req_wdata_i,
   // register answers
   output logic                                 rsp_valid_o,
   input  wire logic                            rsp_ready_i,
   output logic [uart_cfg_pkg::DATA_W-1:0]      rsp_data_o,
   // line coding request
   input  wire logic                            lc_valid_i,
   input  wire logic                            lc_stop_two_i,
   input  wire logic [2:0]                      lc_parity_i,
   input  wire logic [3:0]                      lc_bits_i,
   // uart core control
   output logic                                 rx_enable_o,
   output logic                                 tx_enable_o,
   output logic                                 rx_gate_o,
   output logic                                 stop_two_o,
   output logic [2:0]                           parity_o,
   output logic [3:0]                           char_len_o,
   output logic                                 half_duplex_o,
   output logic [2:0]                           flow_mode_o,
   output logic [7:0]                           resume_character_o,
   output logic [7:0]                           pause_character_o,
   output logic                                 tx_break_o,
   // uart core status
   input  wire logic                            tx_busy_i,
   input  wire logic                            addr_match_i,
   input  wire logic                            bit_tick_i,
   input  wire logic                            overrun_evt_i,
   input  wire logic                            parity_evt_i,
   input  wire logic                            frame_evt_i,
   input  wire logic                            break_evt_i,
   input  wire logic                            break_live_i,
   // handshake to and from the core
   input  wire logic                            rts_n_i,
   input  wire logic                            dtr_n_i,
   output logic                                 cts_n_o,
   output logic                                 dsr_n_o,
   // six shared pins
   input  wire logic [5:0]                      pin_in_i,
   output logic [5:0]                           pin_out_o,
   output logic [5:0]                           pin_oe_o
);
   import uart_cfg_pkg::*;

   typedef enum logic [2:0] {
      DE_IDLE = 3'b001,
      DE_SEND = 3'b010,
      DE_HOLD = 3'b100
   } de_state_t;

   typedef struct packed {
      logic                rx_en;
      logic                tx_en;
      logic [7:0]          fmt;
      logic [3:0]          flow;
      logic [7:0]          resume;
      logic [7:0]          pause;
      logic [3:0]          err;
      logic [15:0]         brk;
      logic [3:0]          turn;
      logic [3:0]          pfunc;
      logic [5:0]          dir;
      logic [5:0]          drv;
      logic [5:0]          s1;
      logic [5:0]          s2;
      logic [5:0]          s3;
      logic [5:0]          level;
      logic [MS_CNT_W-1:0] ms_cnt;
      de_state_t           de;
      logic [3:0]          hold;
   } cfg_state_t;

   cfg_state_t  st_ff;
   cfg_state_t  nxt_st;
   logic        take;
   logic        wr;
   logic        rd;
   logic [15:0] rd_val;
   logic        ms_tick;
   logic        de_req;
   logic        de_on;
   logic        de_level;
   logic [3:0]  err_evt;
   logic [5:0]  agree;

   word_stream_if push_if ();
   word_stream_if pop_if ();

   // answers queue here so a stalled host never loses a word
   two_entry_buffer u_rsp_buf (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .fill_if   (push_if),
      .drain_if  (pop_if)
   );

   // request acceptance; only vendor requests reach the registers
   assign req_ready_o  = push_if.ready;
   assign take         = req_valid_i && push_if.ready; // R23
   assign wr           = take && req_write_i;
   assign rd           = take && !req_write_i;
   assign push_if.valid = take;
   assign push_if.data  = req_write_i ? 16'h0000 : rd_val;
   assign pop_if.ready  = rsp_ready_i;
   assign rsp_valid_o   = pop_if.valid;
   assign rsp_data_o    = pop_if.data;

   // millisecond tick from the system clock
   assign ms_tick = (st_ff.ms_cnt == MS_CNT_W'(MS_CYCLES - 1)); // R25
   assign err_evt = {overrun_evt_i, parity_evt_i, frame_evt_i, break_evt_i};
   assign agree   = ~(st_ff.s2 ^ st_ff.s3);

   // read mux; reserved and unmapped bits read as zero
   always_comb begin
      rd_val = 16'h0000;
      unique case (req_addr_i)
         ADDR_DIR_ENABLE: rd_val = {14'h0000, st_ff.rx_en, st_ff.tx_en};
         ADDR_CHAR_FMT:   rd_val = {8'h00, st_ff.fmt};
         ADDR_HANDSHAKE:  rd_val = {12'h000, st_ff.flow};
         ADDR_RESUME:     rd_val = {8'h00, st_ff.resume};
         ADDR_PAUSE:      rd_val = {8'h00, st_ff.pause};
         ADDR_LINE_ERR:   rd_val = {8'h00, break_live_i, st_ff.err, 3'h0}; // R09
         ADDR_BREAK:      rd_val = st_ff.brk;
         ADDR_TURNAROUND: rd_val = {12'h000, st_ff.turn};
         ADDR_PIN_FUNC:   rd_val = {12'h000, st_ff.pfunc};
         ADDR_PIN_DIR:    rd_val = {10'h000, st_ff.dir};
         ADDR_PIN_LEVEL:  rd_val = {10'h000, st_ff.level}; // R19
         default:         rd_val = 16'h0000;
      endcase
   end

   // driver-enable request for the two automatic modes
   always_comb begin
      de_req = 1'b0;
      if (st_ff.pfunc[2:0] == PF_DE_TX) begin
         de_req = tx_busy_i; // R15
      end else if (st_ff.pfunc[2:0] == PF_DE_ADR) begin
         de_req = tx_busy_i && addr_match_i; // R15
      end
   end

   assign de_on    = (st_ff.de != DE_IDLE);
   assign de_level = st_ff.pfunc[POL_BIT] ? de_on : ~de_on; // R13

   // next state of every register, counter and synchroniser
   always_comb begin
      nxt_st = st_ff;
      // register writes; only defined bits are kept
      if (wr) begin
         unique case (req_addr_i)
            ADDR_DIR_ENABLE: begin
               nxt_st.rx_en = req_wdata_i[ENA_RX_BIT]; // R01
               nxt_st.tx_en = req_wdata_i[ENA_TX_BIT]; // R01
            end
            ADDR_CHAR_FMT:   nxt_st.fmt = req_wdata_i[7:0]; // R02 R03 R04
            ADDR_HANDSHAKE:  nxt_st.flow = req_wdata_i[3:0]; // R05 R06
            ADDR_RESUME:     nxt_st.resume = req_wdata_i[7:0]; // R07
            ADDR_PAUSE:      nxt_st.pause = req_wdata_i[7:0]; // R07
            ADDR_TURNAROUND: nxt_st.turn = req_wdata_i[3:0];
            ADDR_PIN_FUNC:   nxt_st.pfunc = req_wdata_i[3:0];
            ADDR_PIN_DIR:    nxt_st.dir = req_wdata_i[5:0]; // R16
            ADDR_DRIVE_HIGH: nxt_st.drv = st_ff.drv | (req_wdata_i[5:0] & st_ff.dir); // R17
            ADDR_DRIVE_LOW:  nxt_st.drv = st_ff.drv & ~(req_wdata_i[5:0] & st_ff.dir); // R18
            default: begin
            end
         endcase
      end else if (lc_valid_i) begin
         // a register write beats line coding
         nxt_st.fmt = {lc_stop_two_i, lc_parity_i, lc_bits_i}; // R22
      end
      // read clears flags; a new event still sets them
      if (rd && (req_addr_i == ADDR_LINE_ERR)) begin
         nxt_st.err = err_evt; // R26
      end else begin
         nxt_st.err = st_ff.err | err_evt; // R08
      end
      // break countdown; all ones never counts
      if (wr && (req_addr_i == ADDR_BREAK)) begin
         nxt_st.brk = req_wdata_i; // R10 R11
      end else if (ms_tick && (st_ff.brk != 16'h0000) && (st_ff.brk != BREAK_FOREVER)) begin
         nxt_st.brk = st_ff.brk - 16'h0001; // R10
      end
      nxt_st.ms_cnt = ms_tick ? '0 : st_ff.ms_cnt + MS_CNT_W'(1); // R25
      // pins pass three flops; a bit moves once stages two and three agree
      nxt_st.s1    = pin_in_i;
      nxt_st.s2    = st_ff.s1;
      nxt_st.s3    = st_ff.s2;
      nxt_st.level = (st_ff.level & ~agree) | (st_ff.s3 & agree);
      // driver enable; turnaround counted in bit times
      unique case (st_ff.de)
         DE_IDLE: begin
            if (de_req) begin
               nxt_st.de = DE_SEND;
            end
         end
         DE_SEND: begin
            if (!tx_busy_i) begin
               nxt_st.hold = st_ff.turn;
               nxt_st.de = (st_ff.turn == 4'h0) ? DE_IDLE : DE_HOLD; // R12
            end
         end
         DE_HOLD: begin
            if (tx_busy_i) begin
               nxt_st.de = DE_SEND;
            end else if (bit_tick_i) begin
               nxt_st.hold = st_ff.hold - 4'h1; // R25
               if (st_ff.hold == 4'h1) begin
                  nxt_st.de = DE_IDLE; // R12
               end
            end
         end
      endcase
   end

   // one register stage for the whole state
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_ff        <= '0; // R24
         st_ff.fmt    <= FMT_RESET; // R04
         st_ff.resume <= RESUME_RESET; // R07
         st_ff.pause  <= PAUSE_RESET; // R07
         st_ff.de     <= DE_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // core-facing controls
   assign rx_enable_o        = st_ff.rx_en;
   assign tx_enable_o        = st_ff.tx_en;
   assign rx_gate_o          = st_ff.rx_en && !(st_ff.flow[HALF_BIT] && tx_busy_i); // R05
   assign stop_two_o         = st_ff.fmt[FMT_STOP_BIT]; // R02
   assign parity_o           = st_ff.fmt[6:4]; // R03
   assign char_len_o         = st_ff.fmt[3:0]; // R04
   assign half_duplex_o      = st_ff.flow[HALF_BIT];
   assign flow_mode_o        = st_ff.flow[2:0]; // R06
   assign resume_character_o = st_ff.resume;
   assign pause_character_o  = st_ff.pause;
   assign tx_break_o         = (st_ff.brk != 16'h0000); // R10 R11
   assign cts_n_o            = st_ff.level[PIN_CTS];
   assign dsr_n_o            = st_ff.level[PIN_DSR];

   // pin functions override general-purpose direction
   always_comb begin
      pin_oe_o  = st_ff.dir; // R16
      pin_out_o = st_ff.drv;
      unique case (st_ff.pfunc[2:0])
         PF_RTS: begin
            pin_oe_o[PIN_REQ]  = 1'b1; // R14
            pin_out_o[PIN_REQ] = rts_n_i;
            pin_oe_o[PIN_CTS]  = 1'b0;
         end
         PF_DTR: begin
            pin_oe_o[PIN_DTR]  = 1'b1; // R14
            pin_out_o[PIN_DTR] = dtr_n_i;
            pin_oe_o[PIN_DSR]  = 1'b0;
         end
         PF_DE_TX, PF_DE_ADR: begin
            pin_oe_o[PIN_REQ]  = 1'b1; // R15
            pin_out_o[PIN_REQ] = de_level;
         end
         default: begin
            // general-purpose and reserved codes leave pins alone
         end
      endcase
   end

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);

   a_enable_write: assert property ( // R01
      (wr && req_addr_i == ADDR_DIR_ENABLE) |=>
      (rx_enable_o == $past(req_wdata_i[1]) && tx_enable_o == $past(req_wdata_i[0])))
      else $error("enable bits did not follow the write");
   a_format_write: assert property ( // R02
      (wr && req_addr_i == ADDR_CHAR_FMT) |=>
      ({stop_two_o, parity_o, char_len_o} == $past(req_wdata_i[7:0])))
      else $error("format fields did not follow the write");
   a_rx_blocked: assert property ( // R05
      (half_duplex_o && tx_busy_i) |-> !rx_gate_o)
      else $error("receiver open while half-duplex transmit");
   a_err_latch: assert property ( // R08
      parity_evt_i |=> st_ff.err[2] [*1] ##1 (st_ff.err[2] || $past(rd, 1)))
      else $error("parity flag not latched");
   a_err_clear: assert property ( // R26
      (rd && req_addr_i == ADDR_LINE_ERR && err_evt == 4'h0) |=> (st_ff.err == 4'h0))
      else $error("status read did not clear flags");
   a_break_count: assert property ( // R10
      (ms_tick && st_ff.brk > 16'h0000 && st_ff.brk < BREAK_FOREVER && !wr) |=>
      (st_ff.brk == $past(st_ff.brk) - 16'h0001))
      else $error("break count did not step down");
   a_break_hold: assert property ( // R11
      (st_ff.brk == BREAK_FOREVER && !wr) |=> (tx_break_o && st_ff.brk == BREAK_FOREVER))
      else $error("continuous break ended");
   a_de_turnaround: assert property ( // R12
      (st_ff.de == DE_HOLD && !tx_busy_i && !bit_tick_i) |=> (st_ff.de == DE_HOLD))
      else $error("driver enable dropped early");
   a_de_polarity: assert property ( // R13
      (st_ff.pfunc[2:0] == PF_DE_TX) |-> (pin_out_o[PIN_REQ] == (st_ff.pfunc[POL_BIT] ~^ de_on)))
      else $error("driver enable polarity wrong");
   a_pin_set: assert property ( // R17
      (wr && req_addr_i == ADDR_DRIVE_HIGH && st_ff.pfunc[2:0] == PF_GPIO) |=>
      ((pin_out_o & $past(req_wdata_i[5:0] & st_ff.dir)) == $past(req_wdata_i[5:0] & st_ff.dir)))
      else $error("drive-high write did not raise pin");

   c_break_done: cover property (st_ff.brk == 16'h0001 && ms_tick ##1 !tx_break_o);
   c_de_release: cover property (st_ff.de == DE_HOLD ##1 st_ff.de == DE_IDLE);
   c_buffer_full: cover property (rsp_valid_o && !req_ready_o);
endmodule : uart_config_break_gpio_regs

// [test/pin_partner.sv]
// Purpose: far side of the six shared pins
// Assumes: every pin has a pull-up; ext_i is the outside level
// Notes:   a pin that the block drives shows the driven level
`timescale 1ns/1ps
module pin_partner (
   // pins
   input  wire logic [5:0] pin_out_i,
   input  wire logic [5:0] pin_oe_i,
   input  wire logic [5:0] ext_i,
   output logic      [5:0] pin_in_o
);
   // driven pins win over the outside level
   assign pin_in_o = (pin_out_i & pin_oe_i) | (ext_i & ~pin_oe_i);
endmodule : pin_partner

// [test/tb_top.sv]
// Purpose: self-checking bench for the uart configuration block
// Assumes: millisecond tick shortened to MS cycles
// Notes:   random data from a fixed seed, corner cases by hand
`timescale 1ns/1ps
module tb_top;
   import uart_cfg_pkg::*;
   localparam int MS = 8;
   logic        clk_sys_i, rst_b_i, req_valid_i, req_write_i, rsp_ready_i, lc_valid_i;
   logic        lc_stop_two_i, tx_busy_i, addr_match_i, bit_tick_i, overrun_evt_i;
   logic        parity_evt_i, frame_evt_i, break_evt_i, break_live_i, rts_n_i, dtr_n_i;
   logic        req_ready_o, rsp_valid_o, rx_enable_o, tx_enable_o, rx_gate_o, stop_two_o;
   logic        half_duplex_o, tx_break_o, cts_n_o, dsr_n_o;
   logic [15:0] req_addr_i, req_wdata_i, rsp_data_o, rd, d, x;
   logic [2:0]  lc_parity_i, parity_o, flow_mode_o;
   logic [3:0]  lc_bits_i, char_len_o;
   logic [5:0]  pin_in_i, pin_out_o, pin_oe_o, ext;
   logic [7:0]  resume_character_o, pause_character_o;
   int          fails, checked, n;

   uart_config_break_gpio_regs #(.MS_CYCLES(MS)) uart_config_break_gpio_regs_inst (.*);
   pin_partner pin_partner_inst (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_i(ext),
      .pin_in_o(pin_in_i));

   // free-running 250 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   // values after reset; pins pulled high
   function automatic logic [15:0] rst_val(input logic [15:0] a);
      case (a)
         ADDR_CHAR_FMT:  return 16'h0008;
         ADDR_RESUME:    return 16'h0011;
         ADDR_PAUSE:     return 16'h0013;
         ADDR_PIN_LEVEL: return 16'h003F;
         default:        return 16'h0000;
      endcase
   endfunction : rst_val

   // stored bits of each register
   function automatic logic [15:0] rw_mask(input logic [15:0] a);
      case (a)
         ADDR_DIR_ENABLE:                        return 16'h0003;
         ADDR_CHAR_FMT, ADDR_RESUME, ADDR_PAUSE: return 16'h00FF;
         ADDR_HANDSHAKE, ADDR_TURNAROUND:        return 16'h000F;
         ADDR_PIN_FUNC:                          return 16'h000F;
         ADDR_PIN_DIR:                           return 16'h003F;
         default:                                return 16'h0000;
      endcase
   endfunction : rw_mask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run

   // a used-up wait ends the run
   task automatic tmo;
      if (n >= 50) begin
         fails++;
         $display("mismatch wait expected done seen timeout");
         complete_run();
      end
   endtask : tmo

   // one request held until taken; answer in rd
   task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] wd);
      @(posedge clk_sys_i);
      req_valid_i <= 1'b1;
      req_write_i <= w;
      req_addr_i  <= a;
      req_wdata_i <= wd;
      n = 0;
      do @(negedge clk_sys_i); while (!req_ready_o && ++n < 50);
      tmo();
      @(posedge clk_sys_i);
      req_valid_i <= 1'b0;
      do @(negedge clk_sys_i); while (!rsp_valid_o && ++n < 50);
      tmo();
      rd = rsp_data_o;
   endtask : bus

   // main sequence
   initial begin
      {req_valid_i, req_write_i, lc_valid_i, lc_stop_two_i, tx_busy_i, addr_match_i} = '0;
      {bit_tick_i, overrun_evt_i, parity_evt_i, frame_evt_i, break_evt_i, break_live_i} = '0;
      {req_addr_i, req_wdata_i, lc_parity_i, lc_bits_i} = '0;
      {rts_n_i, dtr_n_i, rsp_ready_i, ext} = 9'h1FF;
      rst_b_i = 1'b0;
      fails = 0;
      checked = 0;
      void'($urandom(45000));
      repeat (5) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      // reset values; unmapped places read zero
      for (int a = 16'h40; a <= 16'h50; a++) begin
         bus(1'b0, 16'(a), 16'h0);
         chk("reset", rst_val(16'(a)), rd);
      end
      chk("chars", 16'h1113, {resume_character_o, pause_character_o});
      // random write and read back
      for (int k = 0; k < 42; k++) begin
         d = 16'(16'h40 + k % 14);
         if (d == ADDR_BREAK) continue;
         x = 16'($urandom) & rw_mask(d);
         bus(1'b1, d, x);
         bus(1'b0, d, 16'h0);
         chk("readback", x, rd);
      end
      // format and flow codes reach the core
      for (int p = 0; p < 5; p++) begin
         d = 16'(p * 16 + 7 + p % 3 + p % 2 * 128);
         bus(1'b1, ADDR_CHAR_FMT, d);
         chk("fmt", d, {8'h00, stop_two_o, parity_o, char_len_o});
         bus(1'b1, ADDR_HANDSHAKE, 16'(p));
         chk("flow", 16'(p), {13'h0, flow_mode_o});
      end
      // line coding pulse updates the format
      @(posedge clk_sys_i);
      {lc_valid_i, lc_stop_two_i, lc_parity_i, lc_bits_i} <= 9'h1A7;
      @(posedge clk_sys_i);
      lc_valid_i <= 1'b0;
      bus(1'b0, ADDR_CHAR_FMT, 16'h0);
      chk("line coding", 16'h00A7, rd);
      // half duplex gating
      bus(1'b1, ADDR_DIR_ENABLE, 16'h0002);
      chk("enables", 16'h0002, {14'h0, rx_enable_o, tx_enable_o});
      bus(1'b1, ADDR_PIN_FUNC, 16'h0000);
      for (int h = 0; h < 4; h++) begin
         bus(1'b1, ADDR_HANDSHAKE, 16'(h / 2 * 8));
         @(posedge clk_sys_i) tx_busy_i <= h[0];
         @(negedge clk_sys_i);
         chk("rx gate", 16'(h / 2 * 2 + (h != 3)), {half_duplex_o, rx_gate_o});
      end
      // sticky flags, clear on read
      @(posedge clk_sys_i);
      {overrun_evt_i, parity_evt_i, frame_evt_i, break_evt_i, break_live_i} <= 5'h1F;
      @(posedge clk_sys_i);
      {overrun_evt_i, parity_evt_i, frame_evt_i, break_evt_i, tx_busy_i} <= 5'h00;
      bus(1'b0, ADDR_LINE_ERR, 16'h0);
      chk("errors", 16'h00F8, rd);
      bus(1'b0, ADDR_LINE_ERR, 16'h0);
      chk("errors cleared", 16'h0080, rd);
      // timed break, then endless break
      bus(1'b1, ADDR_BREAK, 16'h0003);
      n = 0;
      while (tx_break_o === 1'b1 && ++n < 50) @(negedge clk_sys_i);
      tmo();
      chk("break length", 1, n >= 2 * MS - 1 && n <= 3 * MS + 1);
      bus(1'b1, ADDR_BREAK, 16'hFFFF);
      repeat (5 * MS) @(negedge clk_sys_i);
      bus(1'b0, ADDR_BREAK, 16'h0);
      chk("endless", 16'hFFFF, rd & {16{tx_break_o}});
      bus(1'b1, ADDR_BREAK, 16'h0000);
      chk("break off", 0, tx_break_o);
      // set and clear act on outputs
      bus(1'b1, ADDR_PIN_FUNC, 16'h0000);
      bus(1'b1, ADDR_PIN_DIR, 16'h000F);
      bus(1'b1, ADDR_DRIVE_HIGH, 16'h003F);
      bus(1'b1, ADDR_PIN_DIR, 16'h003F);
      bus(1'b1, ADDR_DRIVE_LOW, 16'h000C);
      chk("pins", 16'h3F03, {2'h0, pin_oe_o, 2'h0, pin_out_o});
      repeat (5) @(negedge clk_sys_i);
      bus(1'b0, ADDR_PIN_LEVEL, 16'h0);
      chk("level", 16'h0003, rd);
      // handshake modes, both directions
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, ADDR_PIN_FUNC, 16'(1 + k % 2));
         @(posedge clk_sys_i) {rts_n_i, dtr_n_i, ext} <= {8{k[1]}};
         repeat (6) @(negedge clk_sys_i);
         chk("hs out", 16'(k / 2), k % 2 ? pin_out_o[3] : pin_out_o[5]);
         chk("hs in", 16'(k / 2), k % 2 ? dsr_n_o : cts_n_o);
      end
      // driver enable held two bit times
      bus(1'b1, ADDR_TURNAROUND, 16'h0002);
      bus(1'b1, ADDR_PIN_FUNC, 16'h000C);
      chk("de idle", 0, pin_out_o[5]);
      @(posedge clk_sys_i) {tx_busy_i, addr_match_i} <= 2'h3;
      @(posedge clk_sys_i) tx_busy_i <= 1'b0;
      for (int t = 0; t < 2; t++) begin
         repeat (2) @(negedge clk_sys_i);
         chk("de hold", 1, pin_out_o[5]);
         @(posedge clk_sys_i) bit_tick_i <= 1'b1;
         @(posedge clk_sys_i) bit_tick_i <= 1'b0;
      end
      repeat (2) @(negedge clk_sys_i);
      chk("de off", 0, pin_out_o[5]);
      bus(1'b1, ADDR_PIN_FUNC, 16'h0003);
      chk("de low idle", 1, pin_out_o[5]);
      // host stalls, buffer fills, then drains
      @(posedge clk_sys_i);
      {rsp_ready_i, req_valid_i, req_write_i} <= 3'b010;
      req_addr_i <= ADDR_TURNAROUND;
      repeat (4) @(negedge clk_sys_i);
      chk("full", 0, req_ready_o);
      @(posedge clk_sys_i) {rsp_ready_i, req_valid_i} <= 2'b10;
      n = 0;
      repeat (4) begin
         @(negedge clk_sys_i);
         if (rsp_valid_o === 1'b1) chk("drain", 16'h0002, rsp_data_o);
         n += int'(rsp_valid_o === 1'b1);
      end
      chk("drained", 16'h2, 16'(n));
      complete_run();
   end
endmodule : tb_top
